// ### hw/flash_prot_pkg.sv
// Purpose: Shared constants and types for the flash protection command host
// Assumes: Reference clock of 10 MHz; host drives select, serial clock and lanes
// Notes: Opcodes are the device's command codes; the deselect cycle count derives from its time

package flash_prot_pkg;

  // Timing
  localparam int REF_CLK_PERIOD_NS = 100;
  localparam int T_DESELECT_NS = 50;
  localparam int DESELECT_CYCLES_INT =
    ((T_DESELECT_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS < 1) ? 1 :
    (T_DESELECT_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam logic [7:0] DESELECT_CYCLES = 8'(DESELECT_CYCLES_INT);
  localparam int SCLK_HALF_DEFAULT = 2;

  // Frame sizes
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  localparam logic [3:0] VLOCK_DATA_BYTES = 4'h1;
  localparam logic [3:0] SECT_PROT_DATA_BYTES = 4'h2;
  localparam logic [3:0] PASSWORD_DATA_BYTES = 4'h8;

  // Command codes
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_DPD_ENTER = 8'hB9;
  localparam logic [7:0] OPC_DPD_RELEASE = 8'hAB;
  localparam logic [7:0] OPC_RD_SECT_PROT = 8'h2D;
  localparam logic [7:0] OPC_PGM_SECT_PROT = 8'h2C;
  localparam logic [7:0] OPC_RD_VLOCK = 8'hE8;
  localparam logic [7:0] OPC_WR_VLOCK = 8'hE5;
  localparam logic [7:0] OPC_RD_NVLOCK = 8'hE2;
  localparam logic [7:0] OPC_WR_NVLOCK = 8'hE3;
  localparam logic [7:0] OPC_ERASE_NVLOCK = 8'hE4;
  localparam logic [7:0] OPC_RD_FREEZE = 8'hA7;
  localparam logic [7:0] OPC_SET_FREEZE = 8'hA6;
  localparam logic [7:0] OPC_RD_PASSWORD = 8'h27;
  localparam logic [7:0] OPC_WR_PASSWORD = 8'h28;
  localparam logic [7:0] OPC_UNLOCK_PASSWORD = 8'h29;
  localparam logic [7:0] OPC_RD_VLOCK_4B = 8'hE0;
  localparam logic [7:0] OPC_WR_VLOCK_4B = 8'hE1;

  typedef enum logic [3:0] {
    OP_DPD_ENTER = 4'h0, OP_DPD_RELEASE = 4'h1, OP_RD_SECT_PROT = 4'h2,
    OP_PGM_SECT_PROT = 4'h3, OP_RD_VLOCK = 4'h4, OP_WR_VLOCK = 4'h5,
    OP_RD_NVLOCK = 4'h6, OP_WR_NVLOCK = 4'h7, OP_ERASE_NVLOCK = 4'h8,
    OP_RD_FREEZE = 4'h9, OP_SET_FREEZE = 4'hA, OP_RD_PASSWORD = 4'hB,
    OP_WR_PASSWORD = 4'hC, OP_UNLOCK_PASSWORD = 4'hD, OP_RD_VLOCK_4B = 4'hE,
    OP_WR_VLOCK_4B = 4'hF
  } op_t;

  typedef enum logic [1:0] {
    PROTO_EXT = 2'h0, PROTO_DUAL = 2'h1, PROTO_QUAD = 2'h2, PROTO_BAD = 2'h3
  } proto_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_START = 3'h1, ST_SHIFT = 3'h2, ST_STOP = 3'h3, ST_GAP = 3'h4
  } state_t;

  typedef enum logic [2:0] {
    PH_CMD = 3'h0, PH_ADDR = 3'h1, PH_WR = 3'h2, PH_RD = 3'h3, PH_END = 3'h4
  } phase_t;

  typedef struct packed {
    logic [7:0] code;
    logic [2:0] nab;
    logic [3:0] nwr;
    logic isrd;
    logic wren;
    logic ext_only;
  } dec_t;

endpackage

// ### hw/flash_prot_host.sv
// Purpose: Host controller issuing protection and power-down commands to a serial flash
// Assumes: Serial clock derived here from ref_clk; lanes sampled via two flip-flops
// Notes: Mode 0 framing; modifying commands get a write-enable frame first
// Overview of operation
// - Power-down enter B9, release AB, command only
// - Volatile lock read E8, 3/4 address, streaming
// - Volatile lock write E5, one data byte
// - Nonvolatile lock read E2, four address bytes
// - Nonvolatile lock write E3, four address, no data
// - Nonvolatile lock erase E4, command only
// - Freeze bit read A7, extended protocol only
// - Freeze bit set A6, command only
// - Four-byte volatile read E0, four address bytes
// - Four-byte volatile write E1, one data byte
// - Command lanes follow active protocol width
// - Mode-dependent address is four bytes in 4-byte mode
// - Write enable precedes every modifying command

`timescale 1ns/1ps

module flash_prot_host #(
  parameter int SCLK_HALF = flash_prot_pkg::SCLK_HALF_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire flash_prot_pkg::op_t cmd_op,
  input wire flash_prot_pkg::proto_t cmd_proto,
  input wire logic addr_4byte_mode,
  input wire logic [31:0] cmd_addr,
  input wire logic [63:0] cmd_wdata,
  input wire logic [7:0] cmd_rd_len,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_error,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic sel_n,
  output logic sclk,
  output logic [3:0] serial_data_lanes_out,
  output logic [3:0] serial_data_lanes_oe_n,
  input wire logic [3:0] serial_data_lanes_in
);
  import flash_prot_pkg::*;

  function automatic dec_t decode(op_t op, logic mode4);
    dec_t d;
    d = '0;
    unique case (op)
      OP_DPD_ENTER: d.code = OPC_DPD_ENTER;
      OP_DPD_RELEASE: d.code = OPC_DPD_RELEASE;
      OP_RD_SECT_PROT: begin
        d.code = OPC_RD_SECT_PROT;
        d.isrd = 1'b1;
      end
      OP_PGM_SECT_PROT: begin
        d.code = OPC_PGM_SECT_PROT;
        d.nwr = SECT_PROT_DATA_BYTES;
        d.wren = 1'b1;
      end
      OP_RD_VLOCK: begin
        d.code = OPC_RD_VLOCK;
        d.nab = mode4 ? ADDR_BYTES_4 : ADDR_BYTES_3;
        d.isrd = 1'b1;
      end
      OP_WR_VLOCK: begin
        d.code = OPC_WR_VLOCK;
        d.nab = mode4 ? ADDR_BYTES_4 : ADDR_BYTES_3;
        d.nwr = VLOCK_DATA_BYTES;
        d.wren = 1'b1;
      end
      OP_RD_NVLOCK: begin
        d.code = OPC_RD_NVLOCK;
        d.nab = ADDR_BYTES_4;
        d.isrd = 1'b1;
      end
      OP_WR_NVLOCK: begin
        d.code = OPC_WR_NVLOCK;
        d.nab = ADDR_BYTES_4;
        d.wren = 1'b1;
      end
      OP_ERASE_NVLOCK: begin
        d.code = OPC_ERASE_NVLOCK;
        d.wren = 1'b1;
      end
      OP_RD_FREEZE: begin
        d.code = OPC_RD_FREEZE;
        d.isrd = 1'b1;
        d.ext_only = 1'b1;
      end
      OP_SET_FREEZE: begin
        d.code = OPC_SET_FREEZE;
        d.wren = 1'b1;
      end
      OP_RD_PASSWORD: begin
        d.code = OPC_RD_PASSWORD;
        d.isrd = 1'b1;
        d.ext_only = 1'b1;
      end
      OP_WR_PASSWORD: begin
        d.code = OPC_WR_PASSWORD;
        d.nwr = PASSWORD_DATA_BYTES;
        d.wren = 1'b1;
      end
      OP_UNLOCK_PASSWORD: begin
        d.code = OPC_UNLOCK_PASSWORD;
        d.nwr = PASSWORD_DATA_BYTES;
      end
      OP_RD_VLOCK_4B: begin
        d.code = OPC_RD_VLOCK_4B;
        d.nab = ADDR_BYTES_4;
        d.isrd = 1'b1;
      end
      OP_WR_VLOCK_4B: begin
        d.code = OPC_WR_VLOCK_4B;
        d.nab = ADDR_BYTES_4;
        d.nwr = VLOCK_DATA_BYTES;
        d.wren = 1'b1;
      end
    endcase
    return d;
  endfunction

  // Lane mapping, MSB of the byte goes out first
  function automatic logic [3:0] lane_bits(proto_t p, logic [7:0] b);
    lane_bits = (p == PROTO_QUAD) ? b[7:4] :
                (p == PROTO_DUAL) ? {2'b00, b[7:6]} : {3'b000, b[7]};
  endfunction

  function automatic logic [3:0] lane_oe_n(proto_t p);
    lane_oe_n = (p == PROTO_QUAD) ? 4'h0 : (p == PROTO_DUAL) ? 4'hC : 4'hE;
  endfunction

  function automatic logic [7:0] shift_in(proto_t p, logic [7:0] b, logic [3:0] din);
    shift_in = (p == PROTO_QUAD) ? {b[3:0], din} :
               (p == PROTO_DUAL) ? {b[5:0], din[1:0]} : {b[6:0], din[1]};
  endfunction

  function automatic logic [2:0] steps_last(proto_t p);
    steps_last = (p == PROTO_QUAD) ? 3'h1 : (p == PROTO_DUAL) ? 3'h3 : 3'h7;
  endfunction

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

  // Pin input synchroniser
  logic [3:0] lanes_meta;
  logic [3:0] lanes_sync;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lanes_meta <= 4'h0;
      lanes_sync <= 4'h0;
    end else begin
      lanes_meta <= serial_data_lanes_in;
      lanes_sync <= lanes_meta;
    end
  end

  state_t state, next_state;
  phase_t phase, next_phase;
  dec_t dec, next_dec;
  proto_t proto, next_proto;
  logic wren_frame, next_wren_frame;
  logic [31:0] addr, next_addr;
  logic [63:0] wdata, next_wdata;
  logic [7:0] rd_len, next_rd_len;
  logic [7:0] byte_idx, next_byte_idx;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic half, next_half;
  logic [7:0] tmr, next_tmr;
  logic [7:0] shreg, next_shreg;
  logic next_cmd_ready, next_cmd_done, next_cmd_error, next_rd_valid;
  logic [7:0] next_rd_data;
  logic next_sel_n, next_sclk;
  logic [3:0] next_lanes_out, next_lanes_oe_n;

  function automatic logic [7:0] phase_last(phase_t ph, dec_t d, logic [7:0] rl);
    phase_last = (ph == PH_ADDR) ? 8'(d.nab - 3'h1) :
                 (ph == PH_WR) ? 8'(d.nwr - 4'h1) :
                 (ph == PH_RD && rl != 8'h00) ? 8'(rl - 8'h01) : 8'h00;
  endfunction

  function automatic phase_t phase_after(phase_t ph, dec_t d, logic wf);
    phase_after = PH_END;
    if (!wf && ph == PH_CMD && d.nab != 3'h0) begin
      phase_after = PH_ADDR;
    end else if (!wf && (ph == PH_CMD || ph == PH_ADDR)) begin
      phase_after = (d.nwr != 4'h0) ? PH_WR : d.isrd ? PH_RD : PH_END;
    end
  endfunction

  function automatic logic [7:0] byte_for(phase_t ph, logic [7:0] idx, dec_t d,
                                          logic wf, logic [31:0] a, logic [63:0] w);
    logic [1:0] sel;
    sel = 2'(d.nab - 3'h1 - idx[2:0]);
    byte_for = (ph == PH_ADDR) ? a[8*sel +: 8] :
               (ph == PH_WR) ? w[8*idx[2:0] +: 8] :
               wf ? OPC_WRITE_ENABLE : d.code;
  endfunction

  always_comb begin
    logic [7:0] nb;
    phase_t np;
    nb = 8'h00;
    np = PH_END;
    next_state = state;
    next_phase = phase;
    next_dec = dec;
    next_proto = proto;
    next_wren_frame = wren_frame;
    next_addr = addr;
    next_wdata = wdata;
    next_rd_len = rd_len;
    next_byte_idx = byte_idx;
    next_bit_cnt = bit_cnt;
    next_half = half;
    next_tmr = tmr;
    next_shreg = shreg;
    next_cmd_ready = cmd_ready;
    next_cmd_done = 1'b0;
    next_cmd_error = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_sel_n = sel_n;
    next_sclk = sclk;
    next_lanes_out = serial_data_lanes_out;
    next_lanes_oe_n = serial_data_lanes_oe_n;
    unique case (state)
      ST_IDLE: begin
        if (cmd_valid) begin
          next_dec = decode(cmd_op, addr_4byte_mode);
          if (cmd_proto == PROTO_BAD || (next_dec.ext_only && cmd_proto != PROTO_EXT)) begin
            next_cmd_error = 1'b1;
            next_cmd_done = 1'b1;
          end else begin
            next_proto = cmd_proto;
            next_wren_frame = next_dec.wren;
            next_addr = cmd_addr;
            next_wdata = cmd_wdata;
            next_rd_len = cmd_rd_len;
            next_cmd_ready = 1'b0;
            next_state = ST_START;
          end
        end
      end
      ST_START: begin
        nb = byte_for(PH_CMD, 8'h00, dec, wren_frame, addr, wdata);
        next_sel_n = 1'b0;
        next_phase = PH_CMD;
        next_byte_idx = 8'h00;
        next_bit_cnt = steps_last(proto);
        next_shreg = nb;
        next_lanes_out = lane_bits(proto, nb);
        next_lanes_oe_n = lane_oe_n(proto);
        next_sclk = 1'b0;
        next_half = 1'b0;
        next_tmr = HALF_LAST;
        next_state = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (tmr != 8'h00) begin
          next_tmr = tmr - 8'h01;
        end else if (!half) begin
          next_sclk = 1'b1;
          next_half = 1'b1;
          next_tmr = HALF_LAST;
        end else begin
          next_shreg = shift_in(proto, shreg, lanes_sync);
          next_sclk = 1'b0;
          next_half = 1'b0;
          next_tmr = HALF_LAST;
          if (bit_cnt != 3'h0) begin
            next_bit_cnt = bit_cnt - 3'h1;
            if (phase != PH_RD) begin
              next_lanes_out = lane_bits(proto, next_shreg);
            end
          end else begin
            if (phase == PH_RD) begin
              next_rd_valid = 1'b1;
              next_rd_data = next_shreg;
            end
            if (byte_idx != phase_last(phase, dec, rd_len)) begin
              np = phase;
              next_byte_idx = byte_idx + 8'h01;
            end else begin
              np = phase_after(phase, dec, wren_frame);
              next_byte_idx = 8'h00;
            end
            next_phase = np;
            next_bit_cnt = steps_last(proto);
            if (np == PH_END) begin
              next_state = ST_STOP;
            end else if (np == PH_RD) begin
              next_lanes_oe_n = 4'hF;
            end else begin
              nb = byte_for(np, next_byte_idx, dec, wren_frame, addr, wdata);
              next_shreg = nb;
              next_lanes_out = lane_bits(proto, nb);
            end
          end
        end
      end
      ST_STOP: begin
        if (tmr != 8'h00) begin
          next_tmr = tmr - 8'h01;
        end else begin
          next_sel_n = 1'b1;
          next_lanes_oe_n = 4'hF;
          next_lanes_out = 4'h0;
          next_tmr = DESELECT_CYCLES - 8'h01;
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tmr != 8'h00) begin
          next_tmr = tmr - 8'h01;
        end else if (wren_frame) begin
          next_wren_frame = 1'b0;
          next_state = ST_START;
        end else begin
          next_cmd_done = 1'b1;
          next_cmd_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      phase <= PH_CMD;
      dec <= '0;
      proto <= PROTO_EXT;
      wren_frame <= 1'b0;
      addr <= 32'h0;
      wdata <= 64'h0;
      rd_len <= 8'h00;
      byte_idx <= 8'h00;
      bit_cnt <= 3'h0;
      half <= 1'b0;
      tmr <= 8'h00;
      shreg <= 8'h00;
      cmd_ready <= 1'b1;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      sel_n <= 1'b1;
      sclk <= 1'b0;
      serial_data_lanes_out <= 4'h0;
      serial_data_lanes_oe_n <= 4'hF;
    end else begin
      state <= next_state;
      phase <= next_phase;
      dec <= next_dec;
      proto <= next_proto;
      wren_frame <= next_wren_frame;
      addr <= next_addr;
      wdata <= next_wdata;
      rd_len <= next_rd_len;
      byte_idx <= next_byte_idx;
      bit_cnt <= next_bit_cnt;
      half <= next_half;
      tmr <= next_tmr;
      shreg <= next_shreg;
      cmd_ready <= next_cmd_ready;
      cmd_done <= next_cmd_done;
      cmd_error <= next_cmd_error;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      sel_n <= next_sel_n;
      sclk <= next_sclk;
      serial_data_lanes_out <= next_lanes_out;
      serial_data_lanes_oe_n <= next_lanes_oe_n;
    end
  end

  // Checks
  default clocking chk_cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic busy_frame;
  assign busy_frame = (state == ST_SHIFT);

  dpd_frame_a: assert property (
      (state == ST_SHIFT && !wren_frame &&
      (dec.code == OPC_DPD_ENTER || dec.code == OPC_DPD_RELEASE)) |-> phase == PH_CMD)
      else $error("power-down frame left command phase");
  rd_release_a: assert property (
      (busy_frame && phase == PH_RD) |-> serial_data_lanes_oe_n == 4'hF)
      else $error("lanes driven during read");
  vlock_addr_a: assert property (
      (state == ST_START && dec.code == OPC_RD_VLOCK) |->
      dec.nab == (addr_4byte_mode ? ADDR_BYTES_4 : ADDR_BYTES_3))
      else $error("volatile read address width wrong");
  four_addr_a: assert property (
      (state != ST_IDLE && (dec.code == OPC_RD_NVLOCK ||
      dec.code == OPC_WR_NVLOCK || dec.code == OPC_RD_VLOCK_4B ||
      dec.code == OPC_WR_VLOCK_4B)) |-> dec.nab == ADDR_BYTES_4)
      else $error("fixed four byte address violated");
  wr_count_a: assert property (
      (state != ST_IDLE && (dec.code == OPC_WR_VLOCK ||
      dec.code == OPC_WR_VLOCK_4B)) |-> dec.nwr == VLOCK_DATA_BYTES && !dec.isrd)
      else $error("lock write data count wrong");
  nvlock_nodata_a: assert property (
      (busy_frame && dec.code == OPC_WR_NVLOCK) |-> phase != PH_WR && phase != PH_RD)
      else $error("nonvolatile write has data");
  ext_only_a: assert property (
      (state == ST_IDLE && cmd_valid && cmd_proto != PROTO_EXT &&
      (cmd_op == OP_RD_FREEZE || cmd_op == OP_RD_PASSWORD)) |=>
      cmd_error && cmd_done && state == ST_IDLE)
      else $error("ext-only read not refused");
  cmd_lanes_a: assert property (
      (busy_frame && phase == PH_CMD) |-> serial_data_lanes_oe_n == lane_oe_n(proto))
      else $error("command lanes wrong");
  wren_first_a: assert property (
      (state == ST_IDLE && cmd_valid && cmd_proto == PROTO_EXT &&
      (cmd_op == OP_SET_FREEZE || cmd_op == OP_ERASE_NVLOCK)) |=> ##1
      (busy_frame && shreg == OPC_WRITE_ENABLE))
      else $error("write enable missing");
  pwd_count_a: assert property (
      (state != ST_IDLE && (dec.code == OPC_WR_PASSWORD ||
      dec.code == OPC_UNLOCK_PASSWORD)) |->
      dec.nwr == PASSWORD_DATA_BYTES && dec.nab == 3'h0)
      else $error("password frame shape wrong");
  sect_prot_a: assert property (
      (state != ST_IDLE && dec.code == OPC_PGM_SECT_PROT) |->
      dec.nwr == SECT_PROT_DATA_BYTES && dec.wren)
      else $error("sector program shape wrong");
  sel_hold_a: assert property (
      (state == ST_STOP && $rose(sel_n) == 1'b0 && next_state == ST_GAP) |=>
      sel_n && sclk == 1'b0)
      else $error("deselect not clean");

  wren_cov_c: cover property (state == ST_GAP && wren_frame ##1 state == ST_START);
  quad_rd_c: cover property (rd_valid && proto == PROTO_QUAD);
  pwd_wr_c: cover property (cmd_done && dec.code == OPC_WR_PASSWORD);
  err_c: cover property (cmd_error);

endmodule

// ### sim/flash_dev_model.sv
// Purpose: Behavioural serial flash answering protection and power-down frames
// Assumes: Mode 0 framing; lane width of every phase follows the proto input
// Notes: Read byte k of a frame is the code plus k; idle lanes are left to pull-ups

`timescale 1ns/1ps

module flash_dev_model (
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic [3:0] lanes,
  input wire logic [1:0] proto,
  input wire logic mode4,
  output logic [3:0] dev_out,
  output logic [3:0] dev_oe
);
  logic [7:0] rx[$];
  int flen[$];
  int missed_wel = 0;
  logic wel = 1'h0;
  logic rd_ph;
  logic [7:0] sh, code, obyte;
  int w, bits, nb, obits, rdk;

  initial begin
    dev_out = 4'h0;
    dev_oe = 4'h0;
  end

  // Lanes per step follow the protocol
  assign w = (proto == 2'h2) ? 4 : (proto == 2'h1) ? 2 : 1;

  // General purpose register: fixed dummy count, then 64 bytes and zeros
  localparam int GP_DUMMY = 8;

  function automatic logic [7:0] gp_reg_byte(input int k, input logic [7:0] v);
    return (k < 64) ? v : 8'h00;
  endfunction

  function automatic int addr_len(input logic [7:0] c, input logic m4);
    case (c)
      8'hE8, 8'hE5: return m4 ? 4 : 3;
      8'hE2, 8'hE3, 8'hE0, 8'hE1: return 4;
      8'h5A: return 3;
      default: return 0;
    endcase
  endfunction

  always @(negedge sel_n) begin
    bits = 0;
    nb = 0;
    rd_ph = 1'h0;
    obits = 0;
    rdk = 0;
  end

  // Host bits taken on the rising serial clock
  always @(posedge sclk) begin
    if (!sel_n && !rd_ph) begin
      for (int i = w - 1; i >= 0; i--) begin
        sh = {sh[6:0], lanes[(w == 1) ? 0 : i]};
      end
      bits = bits + w;
      if (bits == 8) begin
        if (nb == 0) begin
          code = sh;
        end
        rx.push_back(sh);
        nb++;
        bits = 0;
        // No dummy cycles: output follows the last address byte, or the command byte when there is none
        rd_ph = (code inside {8'hE8, 8'hE2, 8'hA7, 8'hE0, 8'h2D, 8'h27}) &&
          (nb == 1 + addr_len(code, mode4));
      end
    end
  end

  // Output streams until deselect
  always @(negedge sclk) begin
    if (!sel_n && rd_ph) begin
      if (obits == 0) begin
        obyte = code + 8'(rdk);
        rdk++;
        obits = 8;
      end
      dev_oe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h2;
      dev_out = (w == 4) ? obyte[7:4] : (w == 2) ? {2'h0, obyte[7:6]} : {2'h0, obyte[7], 1'h0};
      obyte = obyte << w;
      obits = obits - w;
    end
  end

  always @(posedge sel_n) begin
    dev_oe = 4'h0;
    if (nb > 0) begin
      flen.push_back(nb);
      if (code == 8'h06) begin
        wel = 1'h1;
      end else if (code inside {8'h2C, 8'hE5, 8'hE3, 8'hE4, 8'hA6, 8'h28, 8'hE1}) begin
        // Counted in missed_wel without a prior write enable
        missed_wel += wel ? 0 : 1;
        wel = 1'h0;
      end
    end
  end
endmodule

// ### sim/flash_prot_host_bench.sv
// Purpose: Self-checking bench for the protection command host
// Assumes: Device model on the lanes; released lanes pulled up
// Notes: Every command frame is compared byte by byte against the model's log

`timescale 1ns/1ps

module flash_prot_host_bench;
  import flash_prot_pkg::*;
  logic ref_clk, resetn, cmd_valid, addr_4byte_mode;
  op_t cmd_op;
  proto_t cmd_proto;
  logic [31:0] cmd_addr;
  logic [63:0] cmd_wdata;
  logic [7:0] cmd_rd_len, rd_data;
  logic cmd_ready, cmd_done, cmd_error, rd_valid, sel_n, sclk;
  logic [3:0] lanes_out, lanes_oe_n, lanes, dev_out, dev_oe;
  int err_total, comparisons;
  logic [7:0] exp_rx[$];
  int exp_len[$];

  flash_prot_host #(.SCLK_HALF(2)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_proto(cmd_proto), .addr_4byte_mode(addr_4byte_mode), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_rd_len(cmd_rd_len), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_error(cmd_error), .rd_valid(rd_valid), .rd_data(rd_data),
    .sel_n(sel_n), .sclk(sclk), .serial_data_lanes_out(lanes_out),
    .serial_data_lanes_oe_n(lanes_oe_n), .serial_data_lanes_in(lanes)
  );

  flash_dev_model i_dev (
    .sel_n(sel_n), .sclk(sclk), .lanes(lanes), .proto(cmd_proto),
    .mode4(addr_4byte_mode), .dev_out(dev_out), .dev_oe(dev_oe)
  );

  // Wire level from both drivers, pull-up otherwise
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lanes[i] = !lanes_oe_n[i] ? lanes_out[i] : dev_oe[i] ? dev_out[i] : 1'h1;
    end
  end

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic expect_frame(input logic [7:0] code, input int nab, input int nwr);
    exp_rx.push_back(code);
    for (int i = nab - 1; i >= 0; i--) begin
      exp_rx.push_back(cmd_addr[8 * i +: 8]);
    end
    for (int i = 0; i < nwr; i++) begin
      exp_rx.push_back(cmd_wdata[8 * i +: 8]);
    end
    exp_len.push_back(1 + nab + nwr);
  endtask

  // One command, its read bytes, its error flag and the frames seen by the device
  task automatic run(input op_t op, input proto_t pr, input logic m4, input logic [7:0] code,
    input int nab, input int nwr, input logic we, input int nrd, input logic err);
    int k;
    k = 0;
    if (we && !err) begin
      expect_frame(OPC_WRITE_ENABLE, 0, 0);
    end
    if (!err) begin
      expect_frame(code, nab, nwr);
    end
    @(negedge ref_clk);
    check(cmd_ready, 1'h1);
    cmd_op = op;
    cmd_proto = pr;
    addr_4byte_mode = m4;
    cmd_rd_len = 8'(nrd);
    cmd_valid = 1'h1;
    @(negedge ref_clk);
    cmd_valid = 1'h0;
    repeat (4000) begin
      if (rd_valid === 1'h1) begin
        check(rd_data, code + 8'(k));
        k++;
      end
      if (cmd_done === 1'h1) break;
      @(negedge ref_clk);
    end
    if (cmd_done !== 1'h1) begin
      err_total++;
      stop_test();
    end else begin
      check(cmd_error, err);
      check(k, nrd);
      check(i_dev.rx.size(), exp_rx.size());
      while (exp_rx.size() > 0 && i_dev.rx.size() > 0) begin
        check(i_dev.rx.pop_front(), exp_rx.pop_front());
      end
      check(i_dev.flen.size(), exp_len.size());
      while (exp_len.size() > 0 && i_dev.flen.size() > 0) begin
        check(i_dev.flen.pop_front(), exp_len.pop_front());
      end
      exp_rx.delete();
      exp_len.delete();
      i_dev.rx.delete();
      i_dev.flen.delete();
    end
  endtask

  task automatic t_cmd_only();
    for (int p = 0; p < 3; p++) begin
      run(OP_DPD_ENTER, proto_t'(p), 0, OPC_DPD_ENTER, 0, 0, 0, 0, 0);
      run(OP_DPD_RELEASE, proto_t'(p), 0, OPC_DPD_RELEASE, 0, 0, 0, 0, 0);
      run(OP_ERASE_NVLOCK, proto_t'(p), 0, OPC_ERASE_NVLOCK, 0, 0, 1, 0, 0);
      run(OP_SET_FREEZE, proto_t'(p), 0, OPC_SET_FREEZE, 0, 0, 1, 0, 0);
    end
    $display("test cmd_only done");
  endtask

  task automatic t_locks();
    run(OP_RD_VLOCK, PROTO_EXT, 0, OPC_RD_VLOCK, 3, 0, 0, 3, 0);
    run(OP_RD_VLOCK, PROTO_QUAD, 1, OPC_RD_VLOCK, 4, 0, 0, 2, 0);
    run(OP_WR_VLOCK, PROTO_DUAL, 1, OPC_WR_VLOCK, 4, 1, 1, 0, 0);
    run(OP_WR_VLOCK, PROTO_EXT, 0, OPC_WR_VLOCK, 3, 1, 1, 0, 0);
    run(OP_RD_NVLOCK, PROTO_DUAL, 0, OPC_RD_NVLOCK, 4, 0, 0, 4, 0);
    run(OP_WR_NVLOCK, PROTO_QUAD, 0, OPC_WR_NVLOCK, 4, 0, 1, 0, 0);
    run(OP_RD_VLOCK_4B, PROTO_EXT, 0, OPC_RD_VLOCK_4B, 4, 0, 0, 2, 0);
    run(OP_WR_VLOCK_4B, PROTO_QUAD, 0, OPC_WR_VLOCK_4B, 4, 1, 1, 0, 0);
    $display("test locks done");
  endtask

  task automatic t_freeze_pw();
    run(OP_RD_FREEZE, PROTO_EXT, 0, OPC_RD_FREEZE, 0, 0, 0, 2, 0);
    run(OP_RD_FREEZE, PROTO_DUAL, 0, OPC_RD_FREEZE, 0, 0, 0, 0, 1);
    run(OP_DPD_ENTER, PROTO_BAD, 0, OPC_DPD_ENTER, 0, 0, 0, 0, 1);
    run(OP_RD_PASSWORD, PROTO_EXT, 0, OPC_RD_PASSWORD, 0, 0, 0, 3, 0);
    run(OP_RD_PASSWORD, PROTO_QUAD, 0, OPC_RD_PASSWORD, 0, 0, 0, 0, 1);
    run(OP_WR_PASSWORD, PROTO_DUAL, 0, OPC_WR_PASSWORD, 0, 8, 1, 0, 0);
    run(OP_UNLOCK_PASSWORD, PROTO_QUAD, 0, OPC_UNLOCK_PASSWORD, 0, 8, 0, 0, 0);
    run(OP_RD_SECT_PROT, PROTO_QUAD, 0, OPC_RD_SECT_PROT, 0, 0, 0, 5, 0);
    run(OP_PGM_SECT_PROT, PROTO_EXT, 0, OPC_PGM_SECT_PROT, 0, 2, 1, 0, 0);
    $display("test freeze_pw done");
  endtask

  initial begin
    err_total = 0;
    comparisons = 0;
    resetn = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = OP_DPD_ENTER;
    cmd_proto = PROTO_EXT;
    addr_4byte_mode = 1'h0;
    cmd_addr = 32'hC3A5_5A1E;
    cmd_wdata = 64'hF0E1_D2C3_B4A5_9687;
    cmd_rd_len = 8'h01;
    repeat (6) @(negedge ref_clk);
    resetn = 1'h1;
    check({cmd_ready, sel_n, sclk, lanes_oe_n}, 7'h6F);
    t_cmd_only();
    t_locks();
    t_freeze_pw();
    check(i_dev.missed_wel, 0);
    stop_test();
  end
endmodule
